/* File: logic/emt_bus_timing.sv */
// module: paging and strobe timing of the external data memory port
`timescale 1ns/1ns

module emt_bus_timing
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // special function register port from the core
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic [7:0]       sfr_rdata_o,
  // external data move request from the core
  input  wire logic        xreq_i,
  input  wire logic        xreq_write_i,
  input  wire logic        xreq_short_addr_i,
  input  wire logic [15:0] xreq_addr_i,
  input  wire logic [7:0]  xreq_wdata_i,
  output logic             xreq_busy_o,
  output logic             xreq_done_o,
  output logic [7:0]       xreq_rdata_o,
  // external memory pins
  output logic [15:0]      ext_addr_o,
  output logic [7:0]       ext_data_out_o,
  output logic             ext_data_oe_o,
  input  wire logic [7:0]  ext_data_in_i,
  output logic             ext_rd_n_o,
  output logic             ext_wr_n_o
);
  emt_pkg::emt_state_t state_ff;
  emt_pkg::emt_state_t nxt_state;
  logic [7:0]  timing_ff;
  logic [7:0]  page_ff;
  logic [15:0] addr_ff;
  logic [7:0]  wdata_ff;
  logic        write_ff;
  logic [7:0]  rdata_ff;
  logic        done_ff;
  logic [7:0]  data_sync1_ff;
  logic [7:0]  data_sync2_ff;
  logic        cnt_load;
  logic [emt_pkg::CNT_W-1:0] cnt_val;
  logic        cnt_zero;
  logic [1:0]  setup_f;
  logic [3:0]  strobe_f;
  logic [1:0]  hold_f;

  // field extraction, used for phase loads
  function automatic logic [emt_pkg::CNT_W-1:0] widen2(input logic [1:0] v);
    widen2 = {2'h0, v};
  endfunction : widen2

  assign setup_f  = timing_ff[emt_pkg::SETUP_MSB:emt_pkg::SETUP_LSB];
  assign strobe_f = timing_ff[emt_pkg::STROBE_MSB:emt_pkg::STROBE_LSB];
  assign hold_f   = timing_ff[emt_pkg::HOLD_MSB:emt_pkg::HOLD_LSB];

  // timing register write
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      timing_ff <= emt_pkg::RST_TIMING;
    else if (sfr_wr_i && sfr_addr_i == emt_pkg::ADDR_TIMING)
      timing_ff <= sfr_wdata_i;
  end

  // page select register write
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      page_ff <= emt_pkg::RST_PAGE_SEL;
    else if (sfr_wr_i && sfr_addr_i == emt_pkg::ADDR_PAGE_SEL)
      page_ff <= sfr_wdata_i;
  end

  // register read mux; other addresses belong to other blocks and read zero here
  always_comb
  begin
    sfr_rdata_o = 8'h00;
    if (sfr_addr_i == emt_pkg::ADDR_TIMING)
      sfr_rdata_o = timing_ff;
    else if (sfr_addr_i == emt_pkg::ADDR_PAGE_SEL)
      sfr_rdata_o = page_ff;
  end

  // phase sequencing; a zero-length setup or hold phase is skipped
  always_comb
  begin
    nxt_state = state_ff;
    cnt_load  = 1'b0;
    cnt_val   = emt_pkg::CNT_ZERO;
    unique case (state_ff)
      emt_pkg::EMT_IDLE:
      begin
        if (xreq_i)
        begin
          cnt_load = 1'b1;
          if (setup_f != 2'h0)
          begin
            nxt_state = emt_pkg::EMT_SETUP;
            cnt_val   = widen2(setup_f) - 4'h1;
          end
          else
          begin
            nxt_state = emt_pkg::EMT_STROBE;
            cnt_val   = strobe_f;
          end
        end
      end
      emt_pkg::EMT_SETUP:
      begin
        if (cnt_zero)
        begin
          nxt_state = emt_pkg::EMT_STROBE;
          cnt_load  = 1'b1;
          cnt_val   = strobe_f;
        end
      end
      emt_pkg::EMT_STROBE:
      begin
        if (cnt_zero)
        begin
          cnt_load = 1'b1;
          if (hold_f != 2'h0)
          begin
            nxt_state = emt_pkg::EMT_HOLD;
            cnt_val   = widen2(hold_f) - 4'h1;
          end
          else
            nxt_state = emt_pkg::EMT_IDLE;
        end
      end
      emt_pkg::EMT_HOLD:
      begin
        if (cnt_zero)
          nxt_state = emt_pkg::EMT_IDLE;
      end
      default:
        nxt_state = emt_pkg::EMT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      state_ff <= emt_pkg::EMT_IDLE;
    else
      state_ff <= nxt_state;
  end

  emt_phase_cnt emt_phase_cnt_inst
  (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .load_i     (cnt_load),
    .load_val_i (cnt_val),
    .zero_o     (cnt_zero)
  );

  // capture request; short moves take the upper byte from the page register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      addr_ff  <= 16'h0000;
      wdata_ff <= 8'h00;
      write_ff <= 1'b0;
    end
    else if (state_ff == emt_pkg::EMT_IDLE && xreq_i)
    begin
      addr_ff  <= xreq_short_addr_i ? {page_ff, xreq_addr_i[7:0]} : xreq_addr_i;
      wdata_ff <= xreq_wdata_i;
      write_ff <= xreq_write_i;
    end
  end

  // read data pins are asynchronous to us, so two flops before use
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      data_sync1_ff <= 8'h00;
      data_sync2_ff <= 8'h00;
    end
    else
    begin
      data_sync1_ff <= ext_data_in_i;
      data_sync2_ff <= data_sync1_ff;
    end
  end

  // read data latched at strobe end; memory must drive it early in the strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdata_ff <= 8'h00;
    else if (state_ff == emt_pkg::EMT_STROBE && cnt_zero && !write_ff)
      rdata_ff <= data_sync2_ff;
  end

  // completion pulse when the access returns to idle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      done_ff <= 1'b0;
    else
      done_ff <= (state_ff != emt_pkg::EMT_IDLE) && (nxt_state == emt_pkg::EMT_IDLE);
  end

  // pin drive; address and write data stand through every phase
  assign ext_addr_o     = addr_ff;
  assign ext_data_out_o = wdata_ff;
  assign ext_data_oe_o  = write_ff && (state_ff != emt_pkg::EMT_IDLE);
  assign ext_rd_n_o     = !(state_ff == emt_pkg::EMT_STROBE && !write_ff);
  assign ext_wr_n_o     = !(state_ff == emt_pkg::EMT_STROBE && write_ff);
  assign xreq_busy_o    = (state_ff != emt_pkg::EMT_IDLE);
  assign xreq_done_o    = done_ff;
  assign xreq_rdata_o   = rdata_ff;
endmodule : emt_bus_timing

/* File: logic/emt_phase_cnt.sv */
// module: loadable down counter timing one access phase
`timescale 1ns/1ns
module emt_phase_cnt
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  // control
  input  wire logic                      load_i,
  input  wire logic [emt_pkg::CNT_W-1:0] load_val_i,
  // status
  output logic                           zero_o
);
  logic [emt_pkg::CNT_W-1:0] cnt_ff;

  // load wins over counting so a phase always starts from its full length
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cnt_ff <= emt_pkg::CNT_ZERO;
    else if (load_i)
      cnt_ff <= load_val_i;
    else if (cnt_ff != emt_pkg::CNT_ZERO)
      cnt_ff <= cnt_ff - 4'h1;
  end

  assign zero_o = (cnt_ff == emt_pkg::CNT_ZERO);
endmodule : emt_phase_cnt

/* File: logic/emt_pkg.sv */
// package: register map, field layout and state codes of the external memory timing block
package emt_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_TIMING    = 8'h84;
  localparam logic [7:0] ADDR_PAGE_SEL  = 8'haa;
  // reset values
  localparam logic [7:0] RST_TIMING     = 8'hff;
  localparam logic [7:0] RST_PAGE_SEL   = 8'h00;
  // timing register field positions
  localparam int SETUP_MSB  = 7;
  localparam int SETUP_LSB  = 6;
  localparam int STROBE_MSB = 5;
  localparam int STROBE_LSB = 2;
  localparam int HOLD_MSB   = 1;
  localparam int HOLD_LSB   = 0;
  // phase counter width, wide enough for sixteen strobe cycles
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // access phases, one-hot
  typedef enum logic [3:0] {
    EMT_IDLE   = 4'h1,
    EMT_SETUP  = 4'h2,
    EMT_STROBE = 4'h4,
    EMT_HOLD   = 4'h8
  } emt_state_t;
endpackage : emt_pkg

/* File: sim/emt_bus_timing_checker.sv */
// checker: phase lengths and paging of the external memory port
`timescale 1ns/1ns
module emt_bus_timing_checker
(
  // clock, reset, register port
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic        sfr_wr_i,
  input wire logic [7:0]  sfr_wdata_i,
  // access port and pins
  input wire logic        xreq_i,
  input wire logic        xreq_short_addr_i,
  input wire logic [15:0] xreq_addr_i,
  input wire logic        xreq_busy_o,
  input wire logic        xreq_done_o,
  input wire logic [15:0] ext_addr_o,
  input wire logic        ext_rd_n_o,
  input wire logic        ext_wr_n_o
);
  logic [7:0] pg_ff;
  logic [7:0] tm_ff;
  logic [5:0] cnt_ff;
  logic [5:0] s_w;
  logic [5:0] sw_w;
  logic [5:0] swh_w;
  logic       strb_w;
  // shadow registers, so the checker never trusts the read port
  always_ff @(posedge clk_i)
    if (srst_i)
      pg_ff <= 8'h00;
    else if (sfr_wr_i && sfr_addr_i == 8'haa)
      pg_ff <= sfr_wdata_i;
  always_ff @(posedge clk_i)
    if (srst_i)
      tm_ff <= 8'hff;
    else if (sfr_wr_i && sfr_addr_i == 8'h84)
      tm_ff <= sfr_wdata_i;
  // cycles since busy rose; cleared on every idle cycle
  always_ff @(posedge clk_i)
    if (srst_i || !xreq_busy_o)
      cnt_ff <= 6'h00;
    else
      cnt_ff <= cnt_ff + 6'h01;
  // phase boundaries from the live timing fields
  assign strb_w = ext_rd_n_o & ext_wr_n_o;
  assign s_w    = {4'h0, tm_ff[7:6]};
  assign sw_w   = s_w + {2'h0, tm_ff[5:2]} + 6'h01;
  assign swh_w  = sw_w + {4'h0, tm_ff[1:0]};
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_done;
    xreq_done_o ##1 !xreq_done_o;
  endsequence
  AST_PAGE_ADDR: assert property (xreq_i && !xreq_busy_o |=> ext_addr_o ==
    {$past(xreq_short_addr_i) ? $past(pg_ff) : $past(xreq_addr_i[15:8]), $past(xreq_addr_i[7:0])})
    else $error("wrong external address");
  AST_SETUP_LEN: assert property ($fell(strb_w) |-> cnt_ff == s_w)
    else $error("setup length wrong");
  AST_STROBE_LEN: assert property ($rose(strb_w) |-> cnt_ff == sw_w)
    else $error("strobe width wrong");
  AST_HOLD_LEN: assert property ($fell(xreq_busy_o) |-> cnt_ff == swh_w ##0 s_done)
    else $error("hold length or done wrong");
  AST_PHASE_ORDER: assert property (!strb_w |-> xreq_busy_o && (ext_rd_n_o || ext_wr_n_o))
    else $error("strobe outside access");
  // a request seen while busy must not disturb the address on the pins
  AST_BUSY_ADDR: assert property (xreq_busy_o |=> $stable(ext_addr_o))
    else $error("address moved during access");
endmodule : emt_bus_timing_checker

/* File: sim/emt_bus_timing_test.sv */
// testbench: registers, paged moves and phase timing
`timescale 1ns/1ns
module emt_bus_timing_test;
  logic clk_i, srst_i, sfr_wr_i, xreq_i, xreq_write_i, xreq_short_addr_i, xreq_busy_o, xreq_done_o;
  logic ext_data_oe_o, ext_rd_n_o, ext_wr_n_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, xreq_wdata_i, xreq_rdata_o, ext_data_out_o, ext_data_in_i;
  logic [15:0] xreq_addr_i, ext_addr_o;
  logic [7:0] tmv [4] = '{8'h08, 8'h5d, 8'hbe, 8'hcb};
  int fails, comparisons, n;
  emt_bus_timing emt_bus_timing_inst (.clk_i, .srst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
    .xreq_i, .xreq_write_i, .xreq_short_addr_i, .xreq_addr_i, .xreq_wdata_i, .xreq_busy_o, .xreq_done_o,
    .xreq_rdata_o, .ext_addr_o, .ext_data_out_o, .ext_data_oe_o, .ext_data_in_i, .ext_rd_n_o, .ext_wr_n_o);
  emt_ext_mem emt_ext_mem_inst (.clk_i, .addr_i(ext_addr_o), .data_i(ext_data_out_o), .data_oe_i(ext_data_oe_o),
    .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .data_o(ext_data_in_i));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    sfr_addr_i <= a;
    @(posedge clk_i);
    #1 chk({8'h00, sfr_rdata_o}, {8'h00, e});
  endtask : rd
  // one move; n counts busy cycles until done, bounded
  task automatic xfer(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    xreq_i <= 1'b1;
    xreq_write_i <= w;
    xreq_short_addr_i <= s;
    xreq_addr_i <= a;
    xreq_wdata_i <= d;
    @(posedge clk_i);
    xreq_i <= 1'b0;
    n = 0;
    #1;
    while (xreq_done_o !== 1'b1)
    begin
      if (n > 40)
      begin
        fails++;
        final_report();
      end
      n++;
      @(posedge clk_i);
      #1;
    end
  endtask : xfer
  initial
  begin
    srst_i = 1'b1;
    sfr_wr_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    xreq_i = 1'b0;
    xreq_write_i = 1'b0;
    xreq_short_addr_i = 1'b0;
    xreq_addr_i = 16'h0000;
    xreq_wdata_i = 8'h00;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(8'h84, 8'hff);
    rd(8'haa, 8'h00);
    wr(8'h85, 8'h5a);
    rd(8'h85, 8'h00);
    // shortest access: one-cycle write strobe, no setup or hold
    wr(8'h84, 8'h00);
    xfer(1'b1, 1'b0, 16'h1234, 8'h5a);
    chk(16'(n), 16'h0001);
    foreach (tmv[i])
    begin
      wr(8'h84, tmv[i]);
      rd(8'h84, tmv[i]);
      xfer(1'b1, 1'b0, 16'(16'h0100 + i), 8'(8'h30 + i));
      chk(16'(n), 16'(tmv[i][7:6] + tmv[i][5:2] + tmv[i][1:0] + 1));
      xfer(1'b0, 1'b0, 16'(16'h0100 + i), 8'h00);
      chk({8'h00, xreq_rdata_o}, 16'(16'h0030 + i));
    end
    // paged moves ignore the request's upper byte
    wr(8'haa, 8'hff);
    xfer(1'b1, 1'b1, 16'h5577, 8'hc3);
    xfer(1'b0, 1'b0, 16'hff77, 8'h00);
    chk({8'h00, xreq_rdata_o}, 16'h00c3);
    wr(8'haa, 8'h12);
    xfer(1'b0, 1'b1, 16'hab34, 8'h00);
    chk({8'h00, xreq_rdata_o}, 16'h005a);
    final_report();
  end
endmodule : emt_bus_timing_test
bind emt_bus_timing emt_bus_timing_checker emt_bus_timing_checker_inst (.clk_i, .srst_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_wdata_i, .xreq_i, .xreq_short_addr_i, .xreq_addr_i, .xreq_busy_o, .xreq_done_o, .ext_addr_o, .ext_rd_n_o,
  .ext_wr_n_o);

/* File: sim/emt_ext_mem.sv */
// partner: asynchronous byte-wide memory on the external pins
`timescale 1ns/1ns
module emt_ext_mem
(
  // clock
  input  wire logic        clk_i,
  // pins from the port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        data_oe_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  // read data to the port
  output logic [7:0]       data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  // store only while strobe low and data driven
  always_ff @(posedge clk_i)
    if (!wr_n_i && data_oe_i)
      mem[addr_i] <= data_i;
  always_ff @(posedge clk_i)
    if (!rd_n_i)
      last_ff <= data_o;
  // released bus shows inverted last value, never a stale copy
  assign data_o = rd_n_i ? ~last_ff : mem[addr_i];
endmodule : emt_ext_mem
